/* File: design/fsr_pkg.sv */
/*
  Package for the flash status register block: command codes, reset
  values, field positions, the state encoding and the carrier types.
  Assumes a single 20 MHz reference clock and SPI modes 0 and 3.
*/
package fsr_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_READ_STATUS  = 8'h05; // Stream the status byte
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01; // Write the lock bit

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic       LOCK_RST     = 1'h0;   // Lock bit at power-up
  localparam logic       WEL_RST      = 1'h0;   // Write latch at reset
  localparam logic       FAIL_RST     = 1'h0;   // Failure flag at reset
  localparam logic [2:0] BIT_IDX_MSB  = 3'h7;   // First status bit sent
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;   // Last bit of a byte
  localparam logic [2:0] BIT_CNT_RST  = 3'h0;   // Bit counter start
  localparam logic [3:0] PINS_RST     = 4'hD;   // csN=1 sclk=1 mosi=0 wpN=1

  // ----------------------------------------------------------------
  // Field positions of the write-status data byte
  // ----------------------------------------------------------------
  localparam int WS_LOCK_POS   = 7;  // New lock value
  localparam int WS_GLOBAL_MSB = 5;  // Global protect field, top
  localparam int WS_GLOBAL_LSB = 2;  // Global protect field, bottom

  // ----------------------------------------------------------------
  // Sector summary codes
  // ----------------------------------------------------------------
  localparam int         NUM_SECTORS = 4;
  localparam logic [3:0] SECT_ALL    = 4'hF;  // Every sector protected
  localparam logic [3:0] SECT_NONE   = 4'h0;  // No sector protected
  localparam logic [1:0] SWP_NONE    = 2'h0;  // Summary: none
  localparam logic [1:0] SWP_SOME    = 2'h1;  // Summary: some
  localparam logic [1:0] SWP_ALL     = 2'h3;  // Summary: all

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,  // Chip select high
    ST_OPCODE = 5'h02,  // Shifting in the command code
    ST_STATUS = 5'h04,  // Streaming the status byte
    ST_WRDATA = 5'h08,  // Collecting the write-status byte
    ST_IGNORE = 5'h10   // Unknown or refused command, wait for release
  } fsr_state_t;

  typedef struct packed {
    logic       lock;       // Protection lock bit
    logic       rsvd;       // Reserved, always zero
    logic       fail;       // Program fail flag
    logic       pinMirror;  // Protect pin mirror
    logic [1:0] soft_protect_summary;        // Soft protect summary
    logic       write_latch_flag;        // Write latch flag
    logic       busy;       // Busy flag
  } fsr_status_t;

  typedef struct packed {
    logic csN;   // Chip select, active low
    logic sclk;  // Serial clock from the host
    logic mosi;  // Serial input
    logic wpN;   // Write protect pin, active low
  } fsr_pins_t;

endpackage : fsr_pkg

/* File: design/fsr_sync2.sv */
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous levels; only the second flop is
  read outside this module.
*/
module fsr_sync2 #(
  parameter int             W   = 4,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  // ----------------------------------------------------------------
  // Flops
  // ----------------------------------------------------------------
  logic [W-1:0] stage1_r;  // Metastable stage, read only by stage two

  // First stage catches the pin level
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      stage1_r <= RST;
    else
      stage1_r <= asyncIn;
  end

  // Second stage is the only stage the logic sees
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      syncOut <= RST;
    else
      syncOut <= stage1_r;
  end

endmodule : fsr_sync2

/* File: design/fsr_status_reg.sv */
/*
  Status register logic of a serial flash: decodes read-status and
  write-status on the SPI pins, streams the live status byte and keeps
  the lock bit, the write latch and the failure flag.
  Assumes the program/erase engine, the sector protection registers
  and the other command decoders sit outside and talk over plain ports.
  The serial clock is sampled by ref_clk, so it must stay well below
  a quarter of the reference rate.
*/
// How it works
// - Code 05h starts status output next clock
// - After bit 0, restart at bit 7
// - Each bit sampled live from status
// - Read status accepted even while busy
// - Chip select release ends read, tristates output
// - Bit 7 is the protection lock bit
// - Locked: sector protect commands refused
// - Lock powers up zero, reset command keeps it
// - Pin asserted: lock may only rise
// - Write status stores only bit 7, its frame end clears bit 1
// - Bit 6 always reads zero
// - Bit 5 set when operation failed
// - Aborted operation never sets failure flag
// - Failure flag refreshed after every operation
// - Bit 4 mirrors protect pin level
// - Bits 3:2 summarise sector protection
// - Bit 1 shows the write latch
// - Bit 0 shows busy
// - Write latch cleared by reset and completions
// - Code 01h plus full byte writes lock
module fsr_status_reg
  import fsr_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire fsr_pkg::fsr_pins_t          pinsIn,
  output logic                             soOut,
  output logic                             soOeN,
  input  wire logic                        opBusy,
  input  wire logic                        opEnd,
  input  wire logic                        opFail,
  input  wire logic                        opAbort,
  input  wire logic                        weSet,
  input  wire logic                        weClear,
  input  wire logic                        resetCmd,
  input  wire logic [fsr_pkg::NUM_SECTORS-1:0] sectorProt,
  input  wire logic                        protReq,
  output logic                             protGrant,
  output logic                             globalReq,
  output logic                             globalProtect,
  output fsr_pkg::fsr_status_t             statusOut
);
  import fsr_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fsr_pins_t   pinsSync;       // Pins after two flops
  logic        sclkPrev_r;     // Last synced serial clock
  logic        csPrev_r;       // Last synced chip select
  logic        sclkRise;       // Host sampling edge
  logic        sclkFall;       // Device output edge
  logic        csRise;         // Chip select released
  fsr_state_t  state_r;        // Command state
  logic [2:0]  bitCnt_r;       // Bits of the current byte
  logic [7:0]  shiftReg_r;     // Incoming serial bits
  logic [7:0]  nextByte;       // Byte completed on this rise
  logic [2:0]  bitIdx_r;       // Status bit to drive next
  logic [7:0]  wsData_r;       // Captured write-status byte
  logic        wsGot_r;        // One full data byte seen
  logic        wsEnd;          // Write-status frame closing
  logic        wsValid;        // Frame closed on a byte boundary
  logic        lockAllowed;    // Pin interlock permits the change
  logic        lock_r;         // Protection lock bit
  logic        wel_r;          // Write latch flag
  logic        fail_r;         // Program fail flag
  logic        soOut_r;        // Serial output data
  logic        soOeN_r;        // Serial output enable, low drives
  logic        globalReq_r;    // Global protect request pulse
  logic        globalProt_r;   // Global protect (1) or unprotect (0)
  fsr_status_t status;         // Live status byte
  logic [7:0]  statusByte;     // Same, flat
  logic        liveBit;        // Status bit selected by the index

  // ----------------------------------------------------------------
  // Summary of the sector protection registers
  // ----------------------------------------------------------------
  function automatic logic [1:0] swpSummary(input logic [NUM_SECTORS-1:0] s);
    if (s == SECT_ALL)
      return SWP_ALL;
    else if (s == SECT_NONE)
      return SWP_NONE;
    else
      return SWP_SOME;
  endfunction : swpSummary

  // ----------------------------------------------------------------
  // Pin synchronisation and edge finding
  // ----------------------------------------------------------------
  fsr_sync2 #(
    .W   (4),
    .RST (PINS_RST)
  ) u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .asyncIn (pinsIn),
    .syncOut (pinsSync)
  );

  // Remember last synced levels for edge detection
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sclkPrev_r <= PINS_RST[2];
      csPrev_r   <= PINS_RST[3];
    end
    else
    begin
      sclkPrev_r <= pinsSync.sclk;
      csPrev_r   <= pinsSync.csN;
    end
  end

  assign sclkRise = pinsSync.sclk & ~sclkPrev_r & ~pinsSync.csN;
  assign sclkFall = ~pinsSync.sclk & sclkPrev_r & ~pinsSync.csN;
  assign csRise   = pinsSync.csN & ~csPrev_r;
  assign nextByte = {shiftReg_r[6:0], pinsSync.mosi};

  // ----------------------------------------------------------------
  // Live status byte
  // ----------------------------------------------------------------
  // Built combinationally so every repeated byte carries fresh values
  always_comb
  begin
    status.lock      = lock_r;
    status.rsvd      = 1'h0;
    status.fail      = fail_r;
    status.pinMirror = pinsSync.wpN;
    status.soft_protect_summary       = swpSummary(sectorProt);
    status.write_latch_flag       = wel_r;
    status.busy      = opBusy;
  end

  assign statusByte = status;
  assign liveBit    = statusByte[bitIdx_r];
  assign statusOut  = status;

  // ----------------------------------------------------------------
  // Command state
  // ----------------------------------------------------------------
  // Busy does not gate decoding, so status can be polled mid-operation
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state_r <= ST_IDLE;
    else if (pinsSync.csN)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE:
          state_r <= ST_OPCODE;
        ST_OPCODE:
          if (sclkRise && bitCnt_r == BIT_CNT_LAST)
          begin
            if (nextByte == OPC_READ_STATUS)
              state_r <= ST_STATUS;
            else if (nextByte == OPC_WRITE_STATUS && wel_r)
              state_r <= ST_WRDATA;
            else
              state_r <= ST_IGNORE;
          end
        ST_STATUS, ST_WRDATA, ST_IGNORE:
          state_r <= state_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Input shifting
  // ----------------------------------------------------------------
  // Bits are sampled on the host's rising edge
  always_ff @(posedge ref_clk)
  begin
    if (srst || state_r == ST_IDLE)
    begin
      bitCnt_r   <= BIT_CNT_RST;
      shiftReg_r <= 8'h00;
    end
    else if (sclkRise && (state_r == ST_OPCODE || state_r == ST_WRDATA))
    begin
      bitCnt_r   <= bitCnt_r + 3'h1;
      shiftReg_r <= nextByte;
    end
  end

  // Keep only the first data byte; later bytes are ignored
  always_ff @(posedge ref_clk)
  begin
    if (srst || state_r == ST_IDLE)
    begin
      wsData_r <= 8'h00;
      wsGot_r  <= 1'h0;
    end
    else if (state_r == ST_WRDATA && sclkRise && bitCnt_r == BIT_CNT_LAST && !wsGot_r)
    begin
      wsData_r <= nextByte;
      wsGot_r  <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Status output
  // ----------------------------------------------------------------
  // Bits change on the falling edge so they are stable at the next rise
  always_ff @(posedge ref_clk)
  begin
    if (srst || state_r != ST_STATUS)
    begin
      bitIdx_r <= BIT_IDX_MSB;
      soOut_r  <= 1'h0;
    end
    else if (sclkFall)
    begin
      soOut_r  <= liveBit;
      bitIdx_r <= bitIdx_r - 3'h1;
    end
  end

  // Drive only while streaming and selected
  always_ff @(posedge ref_clk)
  begin
    if (srst || pinsSync.csN || state_r != ST_STATUS)
      soOeN_r <= 1'h1;
    else if (sclkFall)
      soOeN_r <= 1'h0;
  end

  assign soOut = soOut_r;
  assign soOeN = soOeN_r;

  // ----------------------------------------------------------------
  // Write-status completion
  // ----------------------------------------------------------------
  // Only a release on a byte boundary after a full byte is a completion
  assign wsEnd       = csRise && state_r == ST_WRDATA;
  assign wsValid     = wsEnd && wsGot_r && bitCnt_r == BIT_CNT_RST;
  assign lockAllowed = !(~pinsSync.wpN && lock_r && !wsData_r[WS_LOCK_POS]);

  // Lock bit; srst (power-up) or a valid write status with bit 7 low and the pin released clears it, the reset command does not
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      lock_r <= LOCK_RST;
    else if (wsValid && lockAllowed)
      lock_r <= wsData_r[WS_LOCK_POS];
  end

  // Global protect uses the lock value from before the write
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      globalReq_r  <= 1'h0;
      globalProt_r <= 1'h0;
    end
    else
    begin
      globalReq_r  <= wsValid && lockAllowed && !lock_r &&
                      (wsData_r[WS_GLOBAL_MSB:WS_GLOBAL_LSB] == SECT_ALL ||
                       wsData_r[WS_GLOBAL_MSB:WS_GLOBAL_LSB] == SECT_NONE);
      globalProt_r <= wsData_r[WS_GLOBAL_MSB:WS_GLOBAL_LSB] == SECT_ALL;
    end
  end

  assign globalReq     = globalReq_r;
  assign globalProtect = globalProt_r;
  assign protGrant     = protReq & ~lock_r;

  // ----------------------------------------------------------------
  // Write latch and failure flag
  // ----------------------------------------------------------------
  // A set in the same cycle as a clear wins, so the enable is not lost
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      wel_r <= WEL_RST;
    else if (weSet)
      wel_r <= 1'h1;
    else if (wsEnd || opEnd || weClear || resetCmd)
      wel_r <= 1'h0;
  end

  // Every finished or aborted operation overwrites the flag
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      fail_r <= FAIL_RST;
    else if (opEnd)
      fail_r <= opFail & ~opAbort;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence readOpcodeDone;
    state_r == ST_OPCODE && !pinsSync.csN && sclkRise &&
    bitCnt_r == BIT_CNT_LAST && nextByte == OPC_READ_STATUS;
  endsequence

  sequence streamLastBit;
    state_r == ST_STATUS && !pinsSync.csN && sclkFall && bitIdx_r == 3'h0;
  endsequence

  opcode_starts_a: assert property (readOpcodeDone |=> state_r == ST_STATUS)
    else $error("read status code did not start streaming");

  byte_wrap_a: assert property (streamLastBit |=> bitIdx_r == 3'h7)
    else $error("status index did not wrap to bit 7");

  live_bit_a: assert property (state_r == ST_STATUS && !pinsSync.csN && sclkFall
    |=> soOut == $past(liveBit) && !soOeN)
    else $error("output bit not taken from live status");

  release_tristate_a: assert property (csRise |=> soOeN ##1 soOeN)
    else $error("output still driven after release");

  lock_guard_a: assert property (protReq && lock_r |-> !protGrant)
    else $error("sector command granted while locked");

  pin_interlock_a: assert property (lock_r && !pinsSync.wpN |=> lock_r)
    else $error("lock cleared while protect pin asserted");

  reserved_zero_a: assert property (state_r == ST_STATUS && sclkFall && bitIdx_r == 3'h6
    |=> !soOut && statusOut.rsvd == 1'h0)
    else $error("reserved status bit not zero");

  abort_no_fail_a: assert property (opEnd && opAbort |=> !fail_r)
    else $error("aborted operation set failure flag");

  fail_refresh_a: assert property (opEnd && !opAbort |=> fail_r == $past(opFail))
    else $error("failure flag not refreshed");

  // Checks the mirror through both synchroniser flops, not just the copy
  pin_mirror_a: assert property (statusOut.pinMirror == $past(pinsIn.wpN, 2))
    else $error("pin mirror differs from pin");

  busy_bit_a: assert property (streamLastBit |=> soOut == $past(opBusy))
    else $error("busy bit differs from engine");

  latch_clear_a: assert property ((opEnd || wsEnd) && !weSet |=> !wel_r)
    else $error("write latch not cleared after operation");

endmodule : fsr_status_reg

/* File: test/fsr_host_model.sv */
/*
  Host side of the serial link: drives chip select, serial clock and
  serial input, and samples the serial output.
  Assumes ref_clk at 20 MHz; one serial clock lasts 8 reference cycles.
*/
module fsr_host_model
(
  input  wire logic ref_clk,
  input  wire logic soOut,
  input  wire logic soOeN,
  output logic      csN,
  output logic      sclk,
  output logic      mosi
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  logic idleLvl;  // Level the clock parks at between frames

  // Clock parks high (mode 3) and stands still between frames
  initial
  begin
    idleLvl = 1'h1;
    csN  = 1'h1;
    sclk = 1'h1;
    mosi = 1'h0;
  end

  // Select the device and give the synchroniser time to see it
  task automatic frame_open();
    @(posedge ref_clk);
    csN <= 1'h0;
    repeat (4) @(posedge ref_clk);
  endtask : frame_open

  // Park the clock while deselected: 1 for mode 3, 0 for mode 0
  task automatic set_idle(input logic lvl);
    @(posedge ref_clk);
    idleLvl = lvl;
    sclk    <= lvl;
    repeat (4) @(posedge ref_clk);
  endtask : set_idle

  // Shift n bits MSB first; sample each returned bit just before the
  // next fall, where it has surely settled
  task automatic shift_bits(input logic [7:0] txByte, input int n,
                            output logic [7:0] rxByte);
    rxByte = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      sclk <= 1'h0;
      mosi <= txByte[i];
      repeat (4) @(posedge ref_clk);
      sclk <= 1'h1;
      repeat (4) @(posedge ref_clk);
      // An undriven line shows the inverse, so a missing enable is caught
      rxByte = {rxByte[6:0], soOeN ? ~soOut : soOut};
    end
  endtask : shift_bits

  // Release select; the data line no longer holds its last value
  task automatic frame_close();
    csN  <= 1'h1;
    sclk <= idleLvl;
    mosi <= ~mosi;
    repeat (8) @(posedge ref_clk);
  endtask : frame_close

endmodule : fsr_host_model

/* File: test/fsr_status_reg_tb.sv */
/*
  Self-checking bench for the status register block: reads and writes
  the status byte over the serial link and pulses the engine ports.
  Assumes the host model above and a 20 MHz reference clock.
*/
module fsr_status_reg_tb
  import fsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk;        // Reference clock
  logic        srst;           // Synchronous reset
  logic        csN;            // Chip select from host
  logic        sclk;           // Serial clock from host
  logic        mosi;           // Serial data from host
  logic        wpN;            // Write protect pin
  fsr_pins_t   pins;           // Pin group into the block
  logic        soOut;          // Serial data out
  logic        soOeN;          // Output enable, active low
  logic        opBusy;         // Engine busy level
  logic [5:0]  ctl;            // opEnd opFail opAbort weSet weClear resetCmd
  logic [3:0]  sectorProt;     // Sector protection levels
  logic        protReq;        // Sector command request
  logic        protGrant;      // Request allowed
  logic        globalReq;      // Global protect pulse
  logic        globalProtect;  // Protect or unprotect
  fsr_status_t statusOut;      // Live status
  logic [7:0]  rx;             // Byte read back
  logic        gProt;          // Direction of last global request
  int          gReqCnt;        // Global requests seen
  int          cycles;         // Timeout counter
  int          nMismatch;      // Mismatches counted
  int          totalChecks;    // Comparisons made
  logic [5:0]  opv [5] = '{6'h30, 6'h38, 6'h30, 6'h20, 6'h02};
  logic        fexp [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};

  assign pins = {csN, sclk, mosi, wpN};

  fsr_status_reg fsr_status_reg_i (
    .ref_clk(ref_clk), .srst(srst), .pinsIn(pins), .soOut(soOut), .soOeN(soOeN),
    .opBusy(opBusy), .opEnd(ctl[5]), .opFail(ctl[4]), .opAbort(ctl[3]),
    .weSet(ctl[2]), .weClear(ctl[1]), .resetCmd(ctl[0]), .sectorProt(sectorProt),
    .protReq(protReq), .protGrant(protGrant), .globalReq(globalReq),
    .globalProtect(globalProtect), .statusOut(statusOut));

  fsr_host_model fsr_host_model_i (
    .ref_clk(ref_clk), .soOut(soOut), .soOeN(soOeN), .csN(csN), .sclk(sclk), .mosi(mosi));

  // ----------------------------------------------------------------
  // Clock, timeout and monitors
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Whole run needs under two thousand cycles; the ceiling leaves margin
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      nMismatch++;
      conclude();
    end
  end

  // Count global requests, keeping the direction of the last one
  always @(posedge ref_clk)
    if (globalReq === 1'h1)
    begin
      gReqCnt++;
      gProt = globalProtect;
    end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkByte

  task automatic chkBit(input logic got, input logic exp);
    chkByte({7'h00, got}, {7'h00, exp});
  endtask : chkBit

  // One-cycle pulse on the engine ports, then let flags settle
  task automatic pulse(input logic [5:0] v);
    @(posedge ref_clk);
    ctl <= v;
    @(posedge ref_clk);
    ctl <= 6'h00;
    repeat (3) @(posedge ref_clk);
  endtask : pulse

  task automatic readStatus(output logic [7:0] s);
    logic [7:0] d;
    fsr_host_model_i.frame_open();
    fsr_host_model_i.shift_bits(OPC_READ_STATUS, 8, d);
    fsr_host_model_i.shift_bits(8'h00, 8, s);
    fsr_host_model_i.frame_close();
  endtask : readStatus

  // Write-status with n data bits; fewer than 8 is an aborted write
  task automatic writeStatus(input logic [7:0] dat, input int n);
    logic [7:0] d;
    pulse(6'h04);
    fsr_host_model_i.frame_open();
    fsr_host_model_i.shift_bits(OPC_WRITE_STATUS, 8, d);
    fsr_host_model_i.shift_bits(dat, n, d);
    fsr_host_model_i.frame_close();
  endtask : writeStatus

  // Expected status from current inputs and the tracked register bits
  function automatic logic [7:0] expSt(input logic lk, input logic fl, input logic we);
    logic [1:0] soft_protect_summary;
    soft_protect_summary = (sectorProt == 4'hF) ? 2'h3 : (sectorProt == 4'h0) ? 2'h0 : 2'h1;
    return {lk, 1'h0, fl, wpN, soft_protect_summary, we, opBusy};
  endfunction : expSt

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    srst = 1'h1;
    wpN = 1'h1;
    opBusy = 1'h0;
    ctl = 6'h00;
    sectorProt = 4'hF;
    protReq = 1'h0;
    nMismatch = 0;
    totalChecks = 0;
    cycles = 0;
    gReqCnt = 0;
    gProt = 1'h0;
    repeat (16) @(posedge ref_clk);
    srst <= 1'h0;
    repeat (4) @(posedge ref_clk);
    chkBit(soOeN, 1'h1);
    chkByte(statusOut, 8'h1C);
    readStatus(rx);
    chkByte(rx, 8'h1C);
    // Summary codes none, some, all
    for (int i = 0; i < 3; i++)
    begin
      sectorProt <= (i == 0) ? 4'h0 : (i == 1) ? 4'h6 : 4'hF;
      repeat (2) @(posedge ref_clk);
      chkByte(statusOut, expSt(1'h0, 1'h0, 1'h0));
    end
    // Busy read, repeated byte picks up fresh values, then mid-byte release
    opBusy <= 1'h1;
    @(posedge ref_clk);
    fsr_host_model_i.frame_open();
    fsr_host_model_i.shift_bits(OPC_READ_STATUS, 8, rx);
    fsr_host_model_i.shift_bits(8'h00, 8, rx);
    chkByte(rx, 8'h1D);
    wpN <= 1'h0;
    opBusy <= 1'h0;
    sectorProt <= 4'h0;
    fsr_host_model_i.shift_bits(8'h00, 8, rx);
    chkByte(rx, 8'h00);
    chkBit(soOeN, 1'h0);
    fsr_host_model_i.shift_bits(8'h00, 3, rx);
    fsr_host_model_i.frame_close();
    chkBit(soOeN, 1'h1);
    wpN <= 1'h1;
    sectorProt <= 4'hF;
    pulse(6'h04);
    chkByte(statusOut, expSt(1'h0, 1'h0, 1'h1));
    // Write all ones: only the lock bit takes the data, global protect requested
    writeStatus(8'hFF, 8);
    chkByte(statusOut, expSt(1'h1, 1'h0, 1'h0));
    chkByte(8'(gReqCnt), 8'h01);
    chkBit(gProt, 1'h1);
    protReq <= 1'h1;
    @(posedge ref_clk);
    chkBit(protGrant, 1'h0);
    // Pin asserted: clearing the lock is refused, latch still cleared
    wpN <= 1'h0;
    writeStatus(8'h00, 8);
    chkByte(statusOut, expSt(1'h1, 1'h0, 1'h0));
    chkByte(8'(gReqCnt), 8'h01);
    pulse(6'h04);
    pulse(6'h01);
    chkByte(statusOut, expSt(1'h1, 1'h0, 1'h0));
    // Aborted write leaves the lock, then a full write clears it
    wpN <= 1'h1;
    writeStatus(8'h00, 4);
    chkByte(statusOut, expSt(1'h1, 1'h0, 1'h0));
    writeStatus(8'h00, 8);
    chkByte(statusOut, expSt(1'h0, 1'h0, 1'h0));
    chkBit(protGrant, 1'h1);
    chkByte(8'(gReqCnt), 8'h01);
    writeStatus(8'h00, 8);
    chkByte(8'(gReqCnt), 8'h02);
    chkBit(gProt, 1'h0);
    protReq <= 1'h0;
    // Engine outcomes: fail, abort, fail, success, write disable
    for (int i = 0; i < 5; i++)
    begin
      pulse(6'h04);
      pulse(opv[i]);
      chkByte(statusOut, expSt(1'h0, fexp[i], 1'h0));
    end
    readStatus(rx);
    chkByte(rx, expSt(1'h0, 1'h0, 1'h0));
    // Refused frames: write status with the latch clear, unknown code
    fsr_host_model_i.frame_open();
    fsr_host_model_i.shift_bits(OPC_WRITE_STATUS, 8, rx);
    fsr_host_model_i.shift_bits(8'hFF, 8, rx);
    fsr_host_model_i.frame_close();
    chkByte(statusOut, expSt(1'h0, 1'h0, 1'h0));
    chkByte(8'(gReqCnt), 8'h02);
    fsr_host_model_i.frame_open();
    fsr_host_model_i.shift_bits(8'hA5, 8, rx);
    fsr_host_model_i.shift_bits(8'h00, 8, rx);
    chkBit(soOeN, 1'h1);
    fsr_host_model_i.frame_close();
    // Same read with the clock parked low
    fsr_host_model_i.set_idle(1'h0);
    readStatus(rx);
    chkByte(rx, expSt(1'h0, 1'h0, 1'h0));
    conclude();
  end

endmodule : fsr_status_reg_tb
